// ---- hw/maf_filter.sv ----
// Purpose: averaging filter control and running-mean datapath
// Assumes: inputs synchronous to core_clk_i; ce_i freezes all state
// Notes: reads return data in the cycle after the read strobe
//
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/100ps
module maf_filter #(
    parameter int DATA_W = 16,
    parameter int MAX_LEN = 1024
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic measurement_rate_fast_i,
    input wire logic [31:0] trigger_repeat_count_i,
    input wire logic trig_src_external_source_i,
    input wire logic sweep_step_nonzero_i,
    input wire logic trig_delay_auto_i,
    input wire logic trig_free_run_i,
    input wire logic ac_power_cfg_i,
    input wire logic [1:0] resolution_i,
    input wire logic power_range_i,
    input wire logic [DATA_W-1:0] sample_i,
    input wire logic sample_valid_i,
    output logic [DATA_W-1:0] result_o,
    output logic result_valid_o,
    output logic error_pending_o
);
    localparam int AW = $clog2(MAX_LEN);
    localparam int SUM_W = DATA_W + AW + 1;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [SUM_W-1:0] mean_of(input logic [SUM_W-1:0] s,
                                                input logic [10:0] n);
        mean_of = s / {{(SUM_W-11){1'b0}}, n};
    endfunction

    function automatic logic in_range(input logic [31:0] v, input logic [31:0] lo,
                                      input logic [31:0] hi);
        in_range = (v >= lo) && (v <= hi);
    endfunction

    // ----------------------------------------
    // write decode
    // ----------------------------------------
    logic [10:0] man_len_r;
    logic auto_r;
    logic sdet_r;
    logic avg_en_r;
    logic [7:0] buf_cnt_r;
    logic [15:0] err_code_r;
    logic err_pend_r;
    logic wr_len, wr_auto, wr_sdet, wr_avg, wr_buf, rd_err;
    logic len_ok, len_conflict, buf_ok, buf_conflict;
    logic err_set;
    logic [15:0] err_new;

    assign wr_len = ce_i && wr_i && (addr_i == maf_pkg::OFF_LEN);
    assign wr_auto = ce_i && wr_i && (addr_i == maf_pkg::OFF_AUTO);
    assign wr_sdet = ce_i && wr_i && (addr_i == maf_pkg::OFF_SDET);
    assign wr_avg = ce_i && wr_i && (addr_i == maf_pkg::OFF_AVG);
    assign wr_buf = ce_i && wr_i && (addr_i == maf_pkg::OFF_BUF);
    assign rd_err = ce_i && rd_i && (addr_i == maf_pkg::OFF_ERR);
    assign len_ok = in_range(wdata_i, maf_pkg::LEN_LO, maf_pkg::LEN_HI);
    assign len_conflict = measurement_rate_fast_i &&
                          (trigger_repeat_count_i > maf_pkg::TRIG_MANY);
    assign buf_ok = in_range(wdata_i, maf_pkg::BUF_LO, maf_pkg::BUF_HI);
    assign buf_conflict = !trig_src_external_source_i || sweep_step_nonzero_i;

    // ----------------------------------------
    // filter length and mode settings
    // ----------------------------------------
    // length range check
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            man_len_r <= maf_pkg::LEN_RST;
        else if (wr_len && len_ok)
            man_len_r <= wdata_i[10:0];
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            auto_r <= 1'b1;
        else if (ce_i && ac_power_cfg_i)
            auto_r <= 1'b1;
        else if (wr_len && len_ok)
            auto_r <= 1'b0;
        else if (wr_auto)
            auto_r <= wdata_i[0];
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            avg_en_r <= 1'b1;
        else if ((wr_auto && wdata_i[0]) || (ce_i && ac_power_cfg_i))
            avg_en_r <= 1'b1;
        else if (wr_len && len_ok && !len_conflict)
            avg_en_r <= 1'b1;
        else if (wr_avg)
            avg_en_r <= wdata_i[0];
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            sdet_r <= 1'b1;
        else if (wr_sdet)
            sdet_r <= wdata_i[0];
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            buf_cnt_r <= maf_pkg::BUF_RST;
        else if (wr_buf && buf_ok && !buf_conflict)
            buf_cnt_r <= wdata_i[7:0];
    end

    // ----------------------------------------
    // error report
    // ----------------------------------------
    // range errors take priority over conflicts
    always_comb
    begin
        err_set = 1'b0;
        err_new = '0;
        if ((wr_len && !len_ok) || (wr_buf && !buf_ok))
        begin
            err_set = 1'b1;
            err_new = maf_pkg::ERR_RANGE;
        end
        else if ((wr_len && len_conflict) || (wr_buf && buf_conflict))
        begin
            err_set = 1'b1;
            err_new = maf_pkg::ERR_CONFLICT;
        end
    end

    // a new error in the read-clear cycle survives the clear
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            err_pend_r <= 1'b0;
            err_code_r <= '0;
        end
        else if (err_set)
        begin
            err_pend_r <= 1'b1;
            err_code_r <= err_new;
        end
        else if (rd_err)
        begin
            err_pend_r <= 1'b0;
            err_code_r <= '0;
        end
    end

    assign error_pending_o = err_pend_r;

    // ----------------------------------------
    // filter datapath
    // ----------------------------------------
    logic [DATA_W-1:0] mem_r [0:MAX_LEN-1];
    logic [AW-1:0] ptr_r;
    logic [10:0] cnt_r;
    logic [10:0] len_q_r;
    logic [SUM_W-1:0] sum_r;
    logic [10:0] len_act;
    logic sdet_eff, step, restart, take;
    logic [SUM_W-1:0] sum4, m_all, m4, diff, sum_nxt;
    logic [10:0] cnt_nxt;
    logic [DATA_W-1:0] oldest;

    assign len_act = auto_r ? maf_pkg::AUTO_TAB[{resolution_i, power_range_i}]
                            : man_len_r;
    assign sdet_eff = sdet_r && !(trig_delay_auto_i && !trig_free_run_i);
    assign take = ce_i && sample_valid_i;
    assign oldest = mem_r[ptr_r - len_act[AW-1:0]];

    always_comb
    begin
        sum4 = '0;
        for (int i = 1; i <= int'(maf_pkg::STEP_WIN); i++)
            sum4 = sum4 + SUM_W'(mem_r[ptr_r - AW'(i)]);
        m4 = sum4 >> maf_pkg::STEP_WIN_SH;
        m_all = (cnt_r == '0) ? '0 : mean_of(sum_r, cnt_r);
        diff = (m4 > m_all) ? (m4 - m_all) : (m_all - m4);
        step = auto_r && sdet_eff && (cnt_r >= maf_pkg::STEP_WIN) &&
               ((diff << maf_pkg::STEP_SH) > m_all);
    end

    // a length change restarts the average so old entries never leak in
    assign restart = step || (len_act != len_q_r);

    always_comb
    begin
        if (restart)
        begin
            sum_nxt = SUM_W'(sample_i);
            cnt_nxt = 11'h1;
        end
        else if (cnt_r < len_act)
        begin
            sum_nxt = sum_r + SUM_W'(sample_i);
            cnt_nxt = cnt_r + 11'h1;
        end
        else
        begin
            sum_nxt = sum_r + SUM_W'(sample_i) - SUM_W'(oldest);
            cnt_nxt = cnt_r;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (take)
            mem_r[ptr_r] <= sample_i;
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ptr_r <= '0;
            cnt_r <= '0;
            sum_r <= '0;
            len_q_r <= maf_pkg::LEN_RST;
        end
        else if (take)
        begin
            ptr_r <= ptr_r + AW'(1);
            cnt_r <= cnt_nxt;
            sum_r <= sum_nxt;
            len_q_r <= len_act;
        end
        else if (ce_i && (len_act != len_q_r))
        begin
            cnt_r <= '0;
            sum_r <= '0;
            len_q_r <= len_act;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            result_o <= '0;
            result_valid_o <= 1'b0;
        end
        else if (ce_i)
        begin
            result_valid_o <= sample_valid_i;
            if (sample_valid_i)
                result_o <= avg_en_r ? DATA_W'(mean_of(sum_nxt, cnt_nxt)) : sample_i;
        end
    end

    // ----------------------------------------
    // read port
    // ----------------------------------------
    // query values
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rdata_o <= '0;
        else if (ce_i)
        begin
            rdata_o <= '0;
            if (rd_i)
            begin
                unique case (addr_i)
                    maf_pkg::OFF_LEN: rdata_o <= 32'(man_len_r);
                    maf_pkg::OFF_LEN_MIN: rdata_o <= maf_pkg::LEN_LO;
                    maf_pkg::OFF_LEN_MAX: rdata_o <= maf_pkg::LEN_HI;
                    maf_pkg::OFF_AUTO: rdata_o <= 32'(auto_r);
                    maf_pkg::OFF_SDET: rdata_o <= 32'(sdet_r);
                    maf_pkg::OFF_AVG: rdata_o <= 32'(avg_en_r);
                    maf_pkg::OFF_BUF: rdata_o <= 32'(buf_cnt_r);
                    maf_pkg::OFF_BUF_MIN: rdata_o <= maf_pkg::BUF_LO;
                    maf_pkg::OFF_BUF_MAX: rdata_o <= maf_pkg::BUF_HI;
                    maf_pkg::OFF_ERR: rdata_o <= {err_pend_r, 15'h0, err_code_r};
                    maf_pkg::OFF_STAT: rdata_o <= {5'h0, cnt_r, 5'h0, len_act};
                    default: rdata_o <= '0;
                endcase
            end
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence len_wr_good;
        wr_len && len_ok;
    endsequence

    len_range_a: assert property (man_len_r >= 11'h1 && man_len_r <= 11'h400)
        else $error("manual length out of range");
    auto_off_a: assert property (len_wr_good and !ac_power_cfg_i |=> !auto_r)
        else $error("auto stayed on after length write");
    avg_on_a: assert property (len_wr_good and !len_conflict |=> avg_en_r)
        else $error("averaging not enabled by length write");
    len_reject_a: assert property (wr_len && !len_ok |=>
        $stable(man_len_r) && err_code_r == maf_pkg::ERR_RANGE && err_pend_r)
        else $error("bad length not rejected");
    conflict_keep_a: assert property (len_wr_good and (len_conflict && !wr_avg
        && !ac_power_cfg_i) |=> $stable(avg_en_r) && err_code_r == maf_pkg::ERR_CONFLICT)
        else $error("conflict handling wrong");
    auto_avg_a: assert property (wr_auto && wdata_i[0] |=> avg_en_r && auto_r)
        else $error("auto on did not enable averaging");
    ac_auto_a: assert property (ce_i && ac_power_cfg_i |=> auto_r)
        else $error("ac config did not set auto");
    step_clear_a: assert property (take && step |=> cnt_r == 11'h1)
        else $error("step did not clear filter");
    buf_guard_a: assert property (wr_buf && (!buf_ok || buf_conflict)
        |=> $stable(buf_cnt_r) && err_pend_r)
        else $error("bad buffer size accepted");
    raw_pass_a: assert property (take && !avg_en_r |=>
        result_valid_o && result_o == $past(sample_i))
        else $error("raw reading not passed");
    sdet_hold_a: assert property (trig_delay_auto_i && !trig_free_run_i |-> !step)
        else $error("step detect not suppressed");
    // a conflict only counts once the value itself is in range
    buf_conflict_a: assert property (wr_buf && buf_ok && buf_conflict
        |=> err_code_r == maf_pkg::ERR_CONFLICT)
        else $error("buffer conflict not reported");
    avg_write_a: assert property (wr_avg && !ac_power_cfg_i |=>
        avg_en_r == $past(wdata_i[0]))
        else $error("averaging enable not written");
    sdet_write_a: assert property (wr_sdet |=> sdet_r == $past(wdata_i[0]))
        else $error("step detect not written");
endmodule

// ---- hw/maf_pkg.sv ----
// Purpose: constants for the measurement averaging filter
// Assumes: 32-bit register port, byte addresses
// Notes: one aligned word per register
package maf_pkg;
    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [7:0] OFF_LEN = 8'h00;
    localparam logic [7:0] OFF_LEN_MIN = 8'h04;
    localparam logic [7:0] OFF_LEN_MAX = 8'h08;
    localparam logic [7:0] OFF_AUTO = 8'h0c;
    localparam logic [7:0] OFF_SDET = 8'h10;
    localparam logic [7:0] OFF_AVG = 8'h14;
    localparam logic [7:0] OFF_BUF = 8'h18;
    localparam logic [7:0] OFF_BUF_MIN = 8'h1c;
    localparam logic [7:0] OFF_BUF_MAX = 8'h20;
    localparam logic [7:0] OFF_ERR = 8'h24;
    localparam logic [7:0] OFF_STAT = 8'h28;
    // ----------------------------------------
    // limits and reset values
    // ----------------------------------------
    localparam logic [31:0] LEN_LO = 32'h1;
    localparam logic [31:0] LEN_HI = 32'h400;
    localparam logic [10:0] LEN_RST = 11'h4;
    localparam logic [31:0] BUF_LO = 32'h1;
    localparam logic [31:0] BUF_HI = 32'hfa;
    localparam logic [7:0] BUF_RST = 8'h1;
    localparam logic [15:0] ERR_RANGE = 16'hff22;
    localparam logic [15:0] ERR_CONFLICT = 16'hff23;
    localparam logic [10:0] STEP_WIN = 11'h4;
    localparam int STEP_WIN_SH = 2;
    localparam int STEP_SH = 3;
    localparam logic [31:0] TRIG_MANY = 32'h1;
    // ----------------------------------------
    // auto length by resolution (2 bits) and range (1 bit)
    // ----------------------------------------
    localparam logic [10:0] AUTO_TAB [0:7] = '{
        11'h1, 11'h1, 11'h2, 11'h1, 11'h10, 11'h2, 11'h80, 11'h10};
endpackage

// ---- testbench/maf_host_model.sv ----
// Purpose: host side of the register port for the averaging filter
// Assumes: slave never stalls; read data stand one cycle after the strobe
// Notes: each call makes one request; strobes never overlap
`timescale 1ns/100ps
module maf_host_model (
    input wire logic core_clk_i,
    input wire logic [31:0] rdata_i,
    output logic [7:0] addr_o,
    output logic [31:0] wdata_o,
    output logic wr_o,
    output logic rd_o
);
    initial
    begin
        addr_o = 8'h00;
        wdata_o = 32'h0;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge core_clk_i);
        wr_o <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge core_clk_i);
        rd_o <= 1'b0;
        @(negedge core_clk_i);
        d = rdata_i;
    endtask

    task automatic pulsed_setup();
        wr(maf_pkg::OFF_SDET, 32'h0);
    endtask
endmodule

// ---- testbench/test_measurement_averaging_filter.sv ----
// Purpose: self-checking bench for the averaging filter
// Assumes: 250 MHz clock, reset low for six cycles
// Notes: step runs use an automatic length of sixteen
`timescale 1ns/100ps
module test_measurement_averaging_filter;
    logic core_clk_i;
    logic rst_n_i = 1'b0;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic [31:0] rdata;
    logic fast = 1'b0;
    logic [31:0] trig_cnt = 32'h1;
    logic external_source = 1'b0;
    logic sweep = 1'b0;
    logic ac = 1'b0;
    logic dly_auto = 1'b0;
    logic free_run = 1'b1;
    logic [1:0] res = 2'h0;
    logic rng = 1'b0;
    logic [15:0] sample = 16'h0;
    logic sv = 1'b0;
    logic [15:0] result;
    logic result_valid;
    logic err_pend;
    int err_total = 0;
    int cmp_count = 0;

    maf_host_model maf_host_model_i (.core_clk_i(core_clk_i), .rdata_i(rdata), .addr_o(addr),
        .wdata_o(wdata), .wr_o(wr), .rd_o(rd));

    maf_filter maf_filter_i (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
        .measurement_rate_fast_i(fast), .trigger_repeat_count_i(trig_cnt),
        .trig_src_external_source_i(external_source), .sweep_step_nonzero_i(sweep),
        .trig_delay_auto_i(dly_auto), .trig_free_run_i(free_run), .ac_power_cfg_i(ac),
        .resolution_i(res), .power_range_i(rng), .sample_i(sample), .sample_valid_i(sv),
        .result_o(result), .result_valid_o(result_valid), .error_pending_o(err_pend));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        maf_host_model_i.rd(a, d);
        chk(nm, d, exp);
    endtask

    task automatic smp(input logic [15:0] v, input logic [15:0] exp);
        @(posedge core_clk_i);
        sample <= v;
        sv <= 1'b1;
        @(posedge core_clk_i);
        sv <= 1'b0;
        @(negedge core_clk_i);
        chk("valid", {31'h0, result_valid}, 32'h1);
        chk("result", {16'h0, result}, {16'h0, exp});
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        rchk("len", maf_pkg::OFF_LEN, 32'h4);
        rchk("len_min", maf_pkg::OFF_LEN_MIN, 32'h1);
        rchk("len_max", maf_pkg::OFF_LEN_MAX, 32'h400);
        rchk("auto", maf_pkg::OFF_AUTO, 32'h1);
        rchk("sdet", maf_pkg::OFF_SDET, 32'h1);
        rchk("avg", maf_pkg::OFF_AVG, 32'h1);
        rchk("buf", maf_pkg::OFF_BUF, 32'h1);
        rchk("buf_min", maf_pkg::OFF_BUF_MIN, 32'h1);
        rchk("buf_max", maf_pkg::OFF_BUF_MAX, 32'hfa);
        rchk("unmapped", 8'h3c, 32'h0);
        $display("test reset done");
    endtask

    task automatic t_len();
        maf_host_model_i.wr(maf_pkg::OFF_AVG, 32'h0);
        maf_host_model_i.wr(maf_pkg::OFF_LEN, 32'h190);
        rchk("len", maf_pkg::OFF_LEN, 32'h190);
        rchk("auto", maf_pkg::OFF_AUTO, 32'h0);
        rchk("avg", maf_pkg::OFF_AVG, 32'h1);
        maf_host_model_i.wr(maf_pkg::OFF_LEN, 32'h0);
        @(negedge core_clk_i);
        chk("pend", {31'h0, err_pend}, 32'h1);
        rchk("err", maf_pkg::OFF_ERR, 32'h8000ff22);
        maf_host_model_i.wr(maf_pkg::OFF_LEN, 32'h401);
        rchk("err", maf_pkg::OFF_ERR, 32'h8000ff22);
        rchk("len", maf_pkg::OFF_LEN, 32'h190);
        chk("pend", {31'h0, err_pend}, 32'h0);
        maf_host_model_i.wr(maf_pkg::OFF_AVG, 32'h0);
        @(posedge core_clk_i);
        fast <= 1'b1;
        trig_cnt <= 32'h2;
        maf_host_model_i.wr(maf_pkg::OFF_LEN, 32'h8);
        rchk("err", maf_pkg::OFF_ERR, 32'h8000ff23);
        rchk("len", maf_pkg::OFF_LEN, 32'h8);
        rchk("avg", maf_pkg::OFF_AVG, 32'h0);
        @(posedge core_clk_i);
        fast <= 1'b0;
        $display("test length done");
    endtask

    task automatic t_buf();
        maf_host_model_i.wr(maf_pkg::OFF_BUF, 32'h64);
        rchk("err", maf_pkg::OFF_ERR, 32'h8000ff23);
        @(posedge core_clk_i);
        external_source <= 1'b1;
        sweep <= 1'b1;
        maf_host_model_i.wr(maf_pkg::OFF_BUF, 32'h64);
        rchk("err", maf_pkg::OFF_ERR, 32'h8000ff23);
        @(posedge core_clk_i);
        sweep <= 1'b0;
        maf_host_model_i.wr(maf_pkg::OFF_BUF, 32'hfb);
        rchk("err", maf_pkg::OFF_ERR, 32'h8000ff22);
        maf_host_model_i.wr(maf_pkg::OFF_BUF, 32'h0);
        rchk("err", maf_pkg::OFF_ERR, 32'h8000ff22);
        rchk("buf", maf_pkg::OFF_BUF, 32'h1);
        maf_host_model_i.wr(maf_pkg::OFF_BUF, 32'hfa);
        rchk("buf", maf_pkg::OFF_BUF, 32'hfa);
        rchk("err", maf_pkg::OFF_ERR, 32'h0);
        $display("test buffer done");
    endtask

    task automatic t_auto();
        @(posedge core_clk_i);
        ac <= 1'b1;
        @(posedge core_clk_i);
        ac <= 1'b0;
        rchk("auto", maf_pkg::OFF_AUTO, 32'h1);
        rchk("avg", maf_pkg::OFF_AVG, 32'h1);
        maf_host_model_i.wr(maf_pkg::OFF_AVG, 32'h0);
        maf_host_model_i.wr(maf_pkg::OFF_AUTO, 32'h0);
        maf_host_model_i.wr(maf_pkg::OFF_AUTO, 32'h1);
        rchk("avg", maf_pkg::OFF_AVG, 32'h1);
        $display("test auto done");
    endtask

    task automatic t_avg();
        maf_host_model_i.pulsed_setup();
        maf_host_model_i.wr(maf_pkg::OFF_LEN, 32'h4);
        smp(16'h4, 16'h4);
        smp(16'h8, 16'h6);
        smp(16'hc, 16'h8);
        smp(16'h10, 16'ha);
        smp(16'h14, 16'he);
        maf_host_model_i.wr(maf_pkg::OFF_AVG, 32'h0);
        smp(16'h64, 16'h64);
        $display("test average done");
    endtask

    // toggling auto restarts the filter, then a jump on the ninth reading
    task automatic step_run(input int idx, input logic [15:0] last_exp);
        maf_host_model_i.wr(maf_pkg::OFF_AUTO, 32'h0);
        maf_host_model_i.wr(maf_pkg::OFF_AUTO, 32'h1);
        rchk("auto_len", maf_pkg::OFF_STAT, 32'(maf_pkg::AUTO_TAB[idx]));
        repeat (8) smp(16'h100, 16'h100);
        smp(16'h800, 16'h1c7);
        smp(16'h800, last_exp);
    endtask

    task automatic t_step();
        maf_host_model_i.wr(maf_pkg::OFF_SDET, 32'h1);
        @(posedge core_clk_i);
        res <= 2'h2;
        step_run(4, 16'h800);
        @(posedge core_clk_i);
        res <= 2'h3;
        rng <= 1'b1;
        dly_auto <= 1'b1;
        free_run <= 1'b0;
        step_run(7, 16'h266);
        rchk("sdet", maf_pkg::OFF_SDET, 32'h1);
        $display("test step done");
    endtask

    // ----------------------------------------
    // clock, reset, sequence, watchdog
    // ----------------------------------------
    initial
    begin
        core_clk_i = 1'b0;
        forever #2 core_clk_i = ~core_clk_i;
    end

    initial
    begin
        repeat (6) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        t_reset();
        t_len();
        t_buf();
        t_auto();
        t_avg();
        t_step();
        wrap_up();
    end

    // whole run needs well under a thousand cycles
    initial
    begin
        #20000;
        err_total++;
        $display("watchdog expired");
        wrap_up();
    end
endmodule
